// ### rtl/drive_stop_action_selector.sv
// What this block does
// [R01] Quick stop codes 0, 1, 2 stop the motor, then enter switch on disabled.
// [R02] Quick stop codes 5, 6 brake, then hold quick stop active energized.
// [R03] After codes 5 or 6, enable operation returns directly to operation enabled.
// [R04] Shutdown code 1 brakes on slow-down ramp, then enters ready to switch on.
// [R05] Shutdown or disable code 0 removes drive so the motor coasts.
// [R06] Disable code 1 brakes on slow-down ramp, then enters switched on.
// [R07] Control word bit 8 requests halt, braking as the halt code selects.
// [R08] Halt code 1 slow-down ramp, 2 quick-stop ramp; other values reserved.
// [R09] Velocity mode quick-stop deceleration comes from the quick-stop ramp setting.
// [R10] Velocity mode slow-down deceleration comes from the velocity deceleration setting.
// [R11] Reserved option code writes are ignored; the old code stays.
// [R12] Option code is latched at the trigger and held while braking.
//
// Stop action selector with a reduced power state machine behind an APB slave.
// Assumes motor_stopped is an asynchronous standstill level from the ramp generator.
// Assumes one command at a time; while braking only disable voltage is heeded, others are dropped.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module drive_stop_action_selector #(
	parameter int ADDR_W = 18
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Ramp generator
	input  wire logic              motor_stopped,
	output logic                   drive_enable,
	output logic      [1:0]        ramp_sel,
	output logic                   velocity_ramp,
	output logic      [31:0]       decel_speed,
	output logic      [15:0]       decel_time,
	// State
	output logic      [5:0]        power_state
);

	// One record holds every flop so reset and update each stay in one place
	typedef struct packed {
		logic [15:0]          ctrl;
		logic [15:0]          quick_code;
		logic [15:0]          shdn_code;
		logic [15:0]          dis_code;
		logic [15:0]          halt_code;
		logic [7:0]           mode;
		logic [31:0]          vel_dspd;
		logic [31:0]          qck_dspd;
		logic [15:0]          vel_dtim;
		logic [15:0]          qck_dtim;
		logic [2:0]           cmd;
		stop_pkg::state_type  st;
		stop_pkg::state_type  target;
		stop_pkg::action_type act;
		logic                 halt_on;
		stop_pkg::action_type halt_act;
		logic [1:0]           stop_sync;
		logic [31:0]          rdata;
		logic                 ready;
		logic                 err;
		logic                 drv;
		stop_pkg::action_type ramp;
		logic                 vel;
		logic [31:0]          dspd;
		logic [15:0]          dtim;
	} regs_type;

	localparam regs_type RESET_VALUE = '{
		ctrl:       16'h0000,
		quick_code: stop_pkg::RST_QUICK_ACT,
		shdn_code:  stop_pkg::RST_SHDN_ACT,
		dis_code:   stop_pkg::RST_DIS_ACT,
		halt_code:  stop_pkg::RST_HALT_ACT,
		mode:       stop_pkg::RST_MODE,
		vel_dspd:   stop_pkg::RST_VEL_DSPD,
		qck_dspd:   stop_pkg::RST_QCK_DSPD,
		vel_dtim:   stop_pkg::RST_DTIM,
		qck_dtim:   stop_pkg::RST_DTIM,
		cmd:        stop_pkg::CMD_NONE,
		st:         stop_pkg::st_sod,
		target:     stop_pkg::st_sod,
		act:        stop_pkg::act_none,
		halt_on:    1'b0,
		halt_act:   stop_pkg::act_none,
		stop_sync:  2'h0,
		rdata:      32'h00000000,
		ready:      1'b0,
		err:        1'b0,
		drv:        1'b0,
		ramp:       stop_pkg::act_none,
		vel:        1'b0,
		dspd:       32'h00000000,
		dtim:       16'h0000
	};

	regs_type    state_reg;
	regs_type    state_next;
	logic [15:0] idx;
	logic        stopped;

	stop_if dec_bus ();

	option_decoder u_decoder (
		.d (dec_bus.dec)
	);

	assign idx     = 16'(paddr[ADDR_W-1:2]);
	// Only the second synchroniser stage is read by logic
	assign stopped = state_reg.stop_sync[1];

	// [R12] Trigger picks code
	always_comb begin
		dec_bus.evt  = stop_pkg::evt_halt;
		dec_bus.code = state_reg.halt_code;
		if (state_reg.cmd == stop_pkg::CMD_QUICK_STOP) begin
			dec_bus.evt  = stop_pkg::evt_quick;
			dec_bus.code = state_reg.quick_code;
		end else if (state_reg.cmd == stop_pkg::CMD_SHUTDOWN) begin
			dec_bus.evt  = stop_pkg::evt_shutdown;
			dec_bus.code = state_reg.shdn_code;
		end else if (state_reg.cmd == stop_pkg::CMD_DISABLE_OP) begin
			dec_bus.evt  = stop_pkg::evt_disable;
			dec_bus.code = state_reg.dis_code;
		end
	end

	always_comb begin
		state_next           = state_reg;
		state_next.cmd       = stop_pkg::CMD_NONE;
		state_next.ready     = 1'b0;
		state_next.err       = 1'b0;
		state_next.stop_sync = {state_reg.stop_sync[0], motor_stopped};

		// Setup phase: decode and prepare the answer for the access phase
		if (psel && !penable) begin
			state_next.ready = 1'b1;
			state_next.rdata = 32'h00000000;
			if (paddr[1:0] != 2'h0) begin
				state_next.err = 1'b1;
			end else begin
				unique case (idx)
					stop_pkg::IDX_CTRL:      state_next.rdata = {16'h0000, state_reg.ctrl};
					stop_pkg::IDX_VEL_DSPD:  state_next.rdata = state_reg.vel_dspd;
					stop_pkg::IDX_QCK_DSPD:  state_next.rdata = state_reg.qck_dspd;
					stop_pkg::IDX_QUICK_ACT: state_next.rdata = {16'h0000, state_reg.quick_code};
					stop_pkg::IDX_SHDN_ACT:  state_next.rdata = {16'h0000, state_reg.shdn_code};
					stop_pkg::IDX_DIS_ACT:   state_next.rdata = {16'h0000, state_reg.dis_code};
					stop_pkg::IDX_HALT_ACT:  state_next.rdata = {16'h0000, state_reg.halt_code};
					stop_pkg::IDX_MODE:      state_next.rdata = {24'h000000, state_reg.mode};
					stop_pkg::IDX_VEL_DTIM:  state_next.rdata = {16'h0000, state_reg.vel_dtim};
					stop_pkg::IDX_QCK_DTIM:  state_next.rdata = {16'h0000, state_reg.qck_dtim};
					stop_pkg::IDX_COMMAND:   state_next.rdata = 32'h00000000;
					stop_pkg::IDX_STATUS: begin
						state_next.rdata[stop_pkg::ST_STATE_LSB +: 6] = state_reg.st;
						state_next.rdata[stop_pkg::ST_ACT_LSB +: 2]   = state_reg.ramp;
						state_next.rdata[stop_pkg::ST_BRAKE_BIT]      = (state_reg.st == stop_pkg::st_brake);
						state_next.rdata[stop_pkg::ST_HALT_BIT]       = state_reg.halt_on;
						state_next.rdata[stop_pkg::ST_STOP_BIT]       = stopped;
					end
					default:                 state_next.err = 1'b1;
				endcase
			end
		end

		// Access phase: writes land at the edge where pready is seen high
		if (psel && penable && state_reg.ready && !state_reg.err && pwrite) begin
			// [R11] Reject reserved codes
			// A reserved code still gets a clean answer so masters need no error path
			unique case (idx)
				stop_pkg::IDX_CTRL:      state_next.ctrl = pwdata[15:0];
				stop_pkg::IDX_VEL_DSPD:  state_next.vel_dspd = pwdata;
				stop_pkg::IDX_QCK_DSPD:  state_next.qck_dspd = pwdata;
				stop_pkg::IDX_QUICK_ACT: begin
					if (stop_pkg::code_legal(stop_pkg::evt_quick, pwdata[15:0])) begin
						state_next.quick_code = pwdata[15:0];
					end
				end
				stop_pkg::IDX_SHDN_ACT: begin
					if (stop_pkg::code_legal(stop_pkg::evt_shutdown, pwdata[15:0])) begin
						state_next.shdn_code = pwdata[15:0];
					end
				end
				stop_pkg::IDX_DIS_ACT: begin
					if (stop_pkg::code_legal(stop_pkg::evt_disable, pwdata[15:0])) begin
						state_next.dis_code = pwdata[15:0];
					end
				end
				stop_pkg::IDX_HALT_ACT: begin
					if (stop_pkg::code_legal(stop_pkg::evt_halt, pwdata[15:0])) begin
						state_next.halt_code = pwdata[15:0];
					end
				end
				stop_pkg::IDX_MODE:      state_next.mode = pwdata[7:0];
				stop_pkg::IDX_VEL_DTIM:  state_next.vel_dtim = pwdata[15:0];
				stop_pkg::IDX_QCK_DTIM:  state_next.qck_dtim = pwdata[15:0];
				stop_pkg::IDX_COMMAND:   state_next.cmd = pwdata[2:0];
				default: begin
				end
			endcase
		end

		// Power state machine, acting on the command pulse of the previous cycle
		unique case (state_reg.st)
			stop_pkg::st_sod: begin
				if (state_reg.cmd == stop_pkg::CMD_SHUTDOWN) begin
					state_next.st = stop_pkg::st_rtso;
				end
			end

			stop_pkg::st_rtso: begin
				if (state_reg.cmd == stop_pkg::CMD_SWITCH_ON) begin
					state_next.st = stop_pkg::st_so;
				end else if (state_reg.cmd == stop_pkg::CMD_DIS_VOLT || state_reg.cmd == stop_pkg::CMD_QUICK_STOP) begin
					state_next.st = stop_pkg::st_sod;
				end
			end

			stop_pkg::st_so: begin
				if (state_reg.cmd == stop_pkg::CMD_ENABLE_OP) begin
					state_next.st = stop_pkg::st_oe;
				end else if (state_reg.cmd == stop_pkg::CMD_SHUTDOWN) begin
					state_next.st = stop_pkg::st_rtso;
				end else if (state_reg.cmd == stop_pkg::CMD_DIS_VOLT || state_reg.cmd == stop_pkg::CMD_QUICK_STOP) begin
					state_next.st = stop_pkg::st_sod;
				end
			end

			stop_pkg::st_oe: begin
				if (state_reg.cmd == stop_pkg::CMD_DIS_VOLT) begin
					state_next.st      = stop_pkg::st_sod;
					state_next.halt_on = 1'b0;
				end else if (state_reg.cmd == stop_pkg::CMD_QUICK_STOP ||
				             state_reg.cmd == stop_pkg::CMD_SHUTDOWN ||
				             state_reg.cmd == stop_pkg::CMD_DISABLE_OP) begin
					state_next.halt_on = 1'b0;
					// Target is kept so leaving the brake needs no second look at a code that may change
					if (state_reg.cmd == stop_pkg::CMD_QUICK_STOP) begin
						// [R02] Hold quick stop
						state_next.target = dec_bus.stay ? stop_pkg::st_qsa : stop_pkg::st_sod;
					end else if (state_reg.cmd == stop_pkg::CMD_SHUTDOWN) begin
						state_next.target = stop_pkg::st_rtso;
					end else begin
						state_next.target = stop_pkg::st_so;
					end
					// [R05] Coast, no ramp
					if (dec_bus.act == stop_pkg::act_free) begin
						state_next.st = (state_reg.cmd == stop_pkg::CMD_QUICK_STOP) ? stop_pkg::st_sod :
						                state_next.target;
					end else begin
						// [R12] Latch braking action
						state_next.st  = stop_pkg::st_brake;
						state_next.act = dec_bus.act;
					end
				// Halt code is taken on the rising halt bit; a code write during a halt waits for the next one
				// [R07] Halt on bit 8
				end else if (state_reg.ctrl[stop_pkg::CTRL_HALT_BIT] && !state_reg.halt_on) begin
					state_next.halt_on  = 1'b1;
					state_next.halt_act = dec_bus.act;
				end else if (!state_reg.ctrl[stop_pkg::CTRL_HALT_BIT]) begin
					state_next.halt_on = 1'b0;
				end
			end

			stop_pkg::st_brake: begin
				// [R04] Enter after standstill
				// [R06] Enter after standstill
				// Removing voltage cannot wait for standstill, so braking is abandoned
				if (state_reg.cmd == stop_pkg::CMD_DIS_VOLT) begin
					state_next.st  = stop_pkg::st_sod;
					state_next.act = stop_pkg::act_none;
				end else if (stopped) begin
					// [R01] Leave after standstill
					state_next.st  = state_reg.target;
					state_next.act = stop_pkg::act_none;
				end
			end

			stop_pkg::st_qsa: begin
				// [R03] Direct re-enable
				if (state_reg.cmd == stop_pkg::CMD_ENABLE_OP) begin
					state_next.st = stop_pkg::st_oe;
				end else if (state_reg.cmd == stop_pkg::CMD_DIS_VOLT) begin
					state_next.st = stop_pkg::st_sod;
				end
			end

			// An upset state code drops the drive rather than guess where it was
			default: begin
				state_next.st  = stop_pkg::st_sod;
				state_next.act = stop_pkg::act_none;
			end
		endcase

		// Registered outputs follow the next state so they line up with it
		// Quick stop active keeps the drive on so the motor stays energized
		state_next.drv  = (state_next.st == stop_pkg::st_oe) || (state_next.st == stop_pkg::st_brake) ||
		                  (state_next.st == stop_pkg::st_qsa);
		state_next.ramp = stop_pkg::act_none;
		if (state_next.st == stop_pkg::st_brake) begin
			state_next.ramp = state_next.act;
		end else if (state_next.st == stop_pkg::st_oe && state_next.halt_on) begin
			state_next.ramp = state_next.halt_act;
		end
		// Outside velocity mode the ramp generator uses its own mode-dependent figures
		state_next.vel  = (state_next.mode == stop_pkg::MODE_VELOCITY);
		state_next.dspd = 32'h00000000;
		state_next.dtim = 16'h0000;
		if (state_next.vel) begin
			// [R10] Velocity deceleration
			if (state_next.ramp == stop_pkg::act_slow) begin
				state_next.dspd = state_next.vel_dspd;
				state_next.dtim = state_next.vel_dtim;
			// [R09] Quick-stop deceleration
			end else if (state_next.ramp == stop_pkg::act_quick) begin
				state_next.dspd = state_next.qck_dspd;
				state_next.dtim = state_next.qck_dtim;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= RESET_VALUE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata        = state_reg.rdata;
	assign pready        = state_reg.ready;
	assign pslverr       = state_reg.err;
	assign drive_enable  = state_reg.drv;
	assign ramp_sel      = state_reg.ramp;
	assign velocity_ramp = state_reg.vel;
	assign decel_speed   = state_reg.dspd;
	assign decel_time    = state_reg.dtim;
	assign power_state   = state_reg.st;

endmodule

// ### rtl/option_decoder.sv
// Turns an event and its option code into a braking action.
// Assumes codes were already screened for legality at write time.
`timescale 1ns/1ps
module option_decoder (
	stop_if.dec d
);

	always_comb begin
		d.act  = stop_pkg::act_none;
		d.stay = 1'b0;
		unique case (d.evt)
			stop_pkg::evt_quick: begin
				// [R01] Stop then disable
				if (d.code == stop_pkg::OPT_0) begin
					d.act = stop_pkg::act_free;
				end else if (d.code == stop_pkg::OPT_1) begin
					d.act = stop_pkg::act_slow;
				end else if (d.code == stop_pkg::OPT_2) begin
					d.act = stop_pkg::act_quick;
				// [R02] Brake and stay
				end else if (d.code == stop_pkg::OPT_5) begin
					d.act  = stop_pkg::act_slow;
					d.stay = 1'b1;
				end else if (d.code == stop_pkg::OPT_6) begin
					d.act  = stop_pkg::act_quick;
					d.stay = 1'b1;
				end
			end
			stop_pkg::evt_shutdown, stop_pkg::evt_disable: begin
				// [R05] Free wheeling
				if (d.code == stop_pkg::OPT_0) begin
					d.act = stop_pkg::act_free;
				// [R04] Slow-down ramp
				// [R06] Slow-down ramp
				end else if (d.code == stop_pkg::OPT_1) begin
					d.act = stop_pkg::act_slow;
				end
			end
			stop_pkg::evt_halt: begin
				// [R08] Halt ramp choice
				if (d.code == stop_pkg::OPT_1) begin
					d.act = stop_pkg::act_slow;
				end else if (d.code == stop_pkg::OPT_2) begin
					d.act = stop_pkg::act_quick;
				end
			end
		endcase
	end

endmodule

// ### rtl/stop_if.sv
// Carries one stop event and its option code to the decoder, and the decoded action back.
// Assumes the decoder answers combinationally within the same cycle.
`timescale 1ns/1ps
interface stop_if;
	stop_pkg::evt_type    evt;
	logic [15:0]          code;
	stop_pkg::action_type act;
	logic                 stay;

	modport sel (output evt, output code, input act, input stay);
	modport dec (input evt, input code, output act, output stay);
endinterface

// ### rtl/stop_pkg.sv
// Constants and types shared by the stop action selector and its option decoder.
// Assumes a 32-bit APB register bus with word-indexed registers.
package stop_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [15:0] IDX_CTRL       = 16'h6040;
	localparam logic [15:0] IDX_VEL_DSPD   = 16'h6049;
	localparam logic [15:0] IDX_QCK_DSPD   = 16'h604a;
	localparam logic [15:0] IDX_QUICK_ACT  = 16'h605a;
	localparam logic [15:0] IDX_SHDN_ACT   = 16'h605b;
	localparam logic [15:0] IDX_DIS_ACT    = 16'h605c;
	localparam logic [15:0] IDX_HALT_ACT   = 16'h605d;
	localparam logic [15:0] IDX_MODE       = 16'h6060;
	localparam logic [15:0] IDX_VEL_DTIM   = 16'h7000;
	localparam logic [15:0] IDX_QCK_DTIM   = 16'h7001;
	localparam logic [15:0] IDX_COMMAND    = 16'h7002;
	localparam logic [15:0] IDX_STATUS     = 16'h7003;

	// Field positions
	localparam int          CTRL_HALT_BIT  = 8;
	localparam int          ST_STATE_LSB   = 0;
	localparam int          ST_ACT_LSB     = 8;
	localparam int          ST_BRAKE_BIT   = 10;
	localparam int          ST_HALT_BIT    = 11;
	localparam int          ST_STOP_BIT    = 12;

	// Values after reset, and the velocity mode code
	localparam logic [15:0] RST_QUICK_ACT  = 16'h0002;
	localparam logic [15:0] RST_SHDN_ACT   = 16'h0001;
	localparam logic [15:0] RST_DIS_ACT    = 16'h0001;
	localparam logic [15:0] RST_HALT_ACT   = 16'h0001;
	localparam logic [31:0] RST_VEL_DSPD   = 32'h000001f4;
	localparam logic [31:0] RST_QCK_DSPD   = 32'h00001388;
	localparam logic [15:0] RST_DTIM       = 16'h0001;
	localparam logic [7:0]  RST_MODE       = 8'h00;
	localparam logic [7:0]  MODE_VELOCITY  = 8'h02;

	// Option codes
	localparam logic [15:0] OPT_0          = 16'h0000;
	localparam logic [15:0] OPT_1          = 16'h0001;
	localparam logic [15:0] OPT_2          = 16'h0002;
	localparam logic [15:0] OPT_5          = 16'h0005;
	localparam logic [15:0] OPT_6          = 16'h0006;

	// Transition commands written to the command register
	localparam logic [2:0]  CMD_NONE       = 3'h0;
	localparam logic [2:0]  CMD_SHUTDOWN   = 3'h1;
	localparam logic [2:0]  CMD_SWITCH_ON  = 3'h2;
	localparam logic [2:0]  CMD_DISABLE_OP = 3'h3;
	localparam logic [2:0]  CMD_ENABLE_OP  = 3'h4;
	localparam logic [2:0]  CMD_QUICK_STOP = 3'h5;
	localparam logic [2:0]  CMD_DIS_VOLT   = 3'h6;

	typedef enum logic [5:0] {
		st_sod   = 6'h01,
		st_rtso  = 6'h02,
		st_so    = 6'h04,
		st_oe    = 6'h08,
		st_brake = 6'h10,
		st_qsa   = 6'h20
	} state_type;

	typedef enum logic [1:0] {
		act_none  = 2'h0,
		act_free  = 2'h1,
		act_slow  = 2'h2,
		act_quick = 2'h3
	} action_type;

	typedef enum logic [1:0] {
		evt_quick    = 2'h0,
		evt_shutdown = 2'h1,
		evt_disable  = 2'h2,
		evt_halt     = 2'h3
	} evt_type;

	function automatic logic code_legal(evt_type e, logic [15:0] c);
		logic ok;
		ok = 1'b0;
		case (e)
			evt_quick:    ok = (c == OPT_0) || (c == OPT_1) || (c == OPT_2) || (c == OPT_5) || (c == OPT_6);
			evt_shutdown: ok = (c == OPT_0) || (c == OPT_1);
			evt_disable:  ok = (c == OPT_0) || (c == OPT_1);
			evt_halt:     ok = (c == OPT_1) || (c == OPT_2);
			default:      ok = 1'b0;
		endcase
		return ok;
	endfunction

endpackage

// ### testbench/ramp_model.sv
// Ramp generator stand-in: reports standstill a set number of cycles after a ramp starts.
// Assumes the motor runs whenever the drive is on with no ramp selected.
`timescale 1ns/1ps
module ramp_model (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// From the selector
	input  wire logic       drive_enable,
	input  wire logic [1:0] ramp_sel,
	input  wire logic [7:0] stop_delay,
	// Standstill level
	output logic            motor_stopped
);
	int cnt;

	// Coasting counts as instant standstill, which keeps runs short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			motor_stopped <= 1'b1;
		end else if (drive_enable && ramp_sel == 2'h0) begin
			cnt <= 0;
			motor_stopped <= 1'b0;
		end else if (!drive_enable || cnt >= stop_delay) begin
			motor_stopped <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// ### testbench/stop_chk.sv
// Checker for the stop action selector: APB answer timing and braking state relations.
// Assumes it is bound to the selector top module and sees only its ports.
`timescale 1ns/1ps
module stop_chk #(
	parameter int ADDR_W = 18
) (
	// Clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// APB slave
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Ramp generator
	input wire logic              motor_stopped,
	input wire logic              drive_enable,
	input wire logic [1:0]        ramp_sel,
	input wire logic              velocity_ramp,
	input wire logic [31:0]       decel_speed,
	input wire logic [15:0]       decel_time,
	// State
	input wire logic [5:0]        power_state
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence brake_left;
		power_state == 6'h10 ##1 power_state != 6'h10;
	endsequence
	sequence hold_left;
		power_state == 6'h20 ##1 power_state != 6'h20;
	endsequence
	sequence braking_on;
		power_state == 6'h10 ##1 power_state == 6'h10;
	endsequence

	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no access answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside the access answer");
	drive_level_a: assert property (drive_enable == (power_state inside {6'h08, 6'h10, 6'h20}))
		else $error("drive enable does not match state");
	brake_ramp_a: assert property (power_state == 6'h10 |-> ramp_sel inside {2'h2, 2'h3})
		else $error("braking without a ramp");
	brake_exit_a: assert property (brake_left |-> power_state inside {6'h01, 6'h02, 6'h04, 6'h20})
		else $error("braking left to a wrong state");
	qsa_exit_a: assert property (hold_left |-> power_state inside {6'h01, 6'h08})
		else $error("quick stop active left to a wrong state");
	brake_hold_a: assert property (braking_on |-> $stable(ramp_sel))
		else $error("ramp changed during braking");
	stop_wait_a: assert property ($rose(motor_stopped) && power_state == 6'h10 |-> ##[1:5] power_state != 6'h10)
		else $error("braking not ended after standstill");
	fig_zero_a: assert property (!velocity_ramp |-> decel_speed == 32'h0 && decel_time == 16'h0)
		else $error("ramp figures outside velocity mode");
endmodule

// ### testbench/tb.sv
// Testbench: APB master tasks walking every stop option code through the state machine.
// Assumes the ramp model reports standstill after a settable delay.
`timescale 1ns/1ps
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  stop_delay = 8'h04;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        motor_stopped;
	logic        drive_enable;
	logic [1:0]  ramp_sel;
	logic        velocity_ramp;
	logic [31:0] decel_speed;
	logic [15:0] decel_time;
	logic [5:0]  power_state;
	logic [31:0] rd;
	logic        err;
	int          bad_count = 0;
	int          comparisons = 0;
	logic [15:0] regs[4] = '{16'h605a, 16'h605b, 16'h605c, 16'h605d};
	logic [31:0] rst_v[4] = '{32'h2, 32'h1, 32'h1, 32'h1};
	logic [31:0] bad_v[4] = '{32'h3, 32'h2, 32'h2, 32'h0};
	logic [15:0] ev_reg[9] = '{16'h605a, 16'h605a, 16'h605a, 16'h605a, 16'h605a, 16'h605b, 16'h605b, 16'h605c, 16'h605c};
	logic [15:0] ev_code[9] = '{16'h0, 16'h1, 16'h2, 16'h5, 16'h6, 16'h0, 16'h1, 16'h0, 16'h1};
	logic [2:0]  ev_cmd[9] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h1, 3'h1, 3'h3, 3'h3};
	logic [1:0]  ev_ramp[9] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0, 2'h2};
	logic [5:0]  ev_end[9] = '{6'h01, 6'h01, 6'h01, 6'h20, 6'h20, 6'h02, 6'h02, 6'h04, 6'h04};

	always #2 pclk = ~pclk;

	drive_stop_action_selector dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.motor_stopped(motor_stopped), .drive_enable(drive_enable), .ramp_sel(ramp_sel),
		.velocity_ramp(velocity_ramp), .decel_speed(decel_speed), .decel_time(decel_time),
		.power_state(power_state));
	ramp_model ramp_u (.pclk(pclk), .presetn(presetn), .drive_enable(drive_enable), .ramp_sel(ramp_sel),
		.stop_delay(stop_delay), .motor_stopped(motor_stopped));

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One edge passes after release so back-to-back calls never assign psel twice in a step
	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_state(input logic [5:0] exp);
		int n;
		n = 0;
		while (power_state !== exp && n < 64) begin
			@(posedge pclk);
			n++;
		end
		check("power_state", {26'h0, exp}, {26'h0, power_state});
	endtask

	task automatic cmd(input logic [2:0] c, input logic [5:0] exp);
		apb(1'b1, stop_pkg::IDX_COMMAND, {29'h0, c});
		wait_state(exp);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		bad_count++;
		give_verdict();
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (regs[i]) begin
			apb(1'b0, regs[i], 32'h0);
			check("reset value", rst_v[i], rd);
			apb(1'b1, regs[i], bad_v[i]);
			apb(1'b0, regs[i], 32'h0);
			check("kept after reserved write", rst_v[i], rd);
		end
		apb(1'b0, 16'h1234, 32'h0);
		check("unmapped error", 32'h1, {31'h0, err});
		$display("test registers done");
		apb(1'b1, stop_pkg::IDX_MODE, 32'h2);
		foreach (ev_reg[i]) begin
			stop_delay <= (i % 2) ? 8'h1e : 8'h03;
			apb(1'b1, ev_reg[i], {16'h0, ev_code[i]});
			cmd(stop_pkg::CMD_SHUTDOWN, 6'h02);
			cmd(stop_pkg::CMD_SWITCH_ON, 6'h04);
			cmd(stop_pkg::CMD_ENABLE_OP, 6'h08);
			apb(1'b1, stop_pkg::IDX_COMMAND, {29'h0, ev_cmd[i]});
			repeat (2) @(posedge pclk);
			check("stop ramp", {30'h0, ev_ramp[i]}, {30'h0, ramp_sel});
			wait_state(ev_end[i]);
			if (ev_end[i] == 6'h20) begin
				check("energized hold", 32'h1, {31'h0, drive_enable});
				cmd(stop_pkg::CMD_ENABLE_OP, 6'h08);
			end
			cmd(stop_pkg::CMD_DIS_VOLT, 6'h01);
			$display("test stop event %0d done", i);
		end
		cmd(stop_pkg::CMD_SHUTDOWN, 6'h02);
		cmd(stop_pkg::CMD_SWITCH_ON, 6'h04);
		cmd(stop_pkg::CMD_ENABLE_OP, 6'h08);
		for (int c = 1; c <= 2; c++) begin
			apb(1'b1, stop_pkg::IDX_HALT_ACT, c);
			apb(1'b1, stop_pkg::IDX_CTRL, 32'h100);
			@(posedge pclk);
			check("halt ramp", c + 1, {30'h0, ramp_sel});
			check("velocity mode", 32'h1, {31'h0, velocity_ramp});
			check("decel speed", (c == 1) ? 32'h1f4 : 32'h1388, decel_speed);
			check("decel time", 32'h1, {16'h0, decel_time});
			apb(1'b0, stop_pkg::IDX_STATUS, 32'h0);
			check("status", 32'h808 | ((c + 1) << 8), rd & 32'hfff);
			apb(1'b1, stop_pkg::IDX_HALT_ACT, 3 - c);
			check("halt code held", c + 1, {30'h0, ramp_sel});
			apb(1'b1, stop_pkg::IDX_CTRL, 32'h0);
			@(posedge pclk);
			check("halt released", 32'h0, {30'h0, ramp_sel});
			$display("test halt code %0d done", c);
		end
		apb(1'b1, stop_pkg::IDX_MODE, 32'h0);
		apb(1'b1, stop_pkg::IDX_CTRL, 32'h100);
		@(posedge pclk);
		check("figures outside velocity", 32'h0, decel_speed | {31'h0, velocity_ramp});
		apb(1'b1, stop_pkg::IDX_CTRL, 32'h0);
		stop_delay <= 8'h1e;
		apb(1'b1, stop_pkg::IDX_COMMAND, {29'h0, stop_pkg::CMD_QUICK_STOP});
		cmd(stop_pkg::CMD_DIS_VOLT, 6'h01);
		$display("test mode and abort done");
		give_verdict();
	end
endmodule

bind drive_stop_action_selector stop_chk #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .motor_stopped(motor_stopped), .drive_enable(drive_enable), .ramp_sel(ramp_sel),
	.velocity_ramp(velocity_ramp), .decel_speed(decel_speed), .decel_time(decel_time),
	.power_state(power_state));
